/* logic/vcr_vc0_resource_regs.sv */
// vcr_vc0_resource_regs: capability, control and table status registers
// of virtual channel resource 0, reached over APB. Assumes the table
// entry logic pulses tableEntryWr on clk_sys and the arbiter takes
// one table word per tableLoadStrobe.
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - time slots field reads zero, read-only
// - table offset reads 0x2 upstream, 0x0 downstream
// - class map resets 0xFF, bit 0 fixed
// - writing load trigger copies table to arbiter
// - load only when selected scheme uses table
// - writing zero to trigger does nothing
// - load trigger acts only in upstream port
// - load trigger always reads zero
// - scheme select writable, resets zero, any 3-bit value stored
// - channel identifier reads zero, read-only
// - channel enable reads one, read-only
// - capability bits: 0x3 upstream, 0x1 downstream
// - status sets on entry write on upstream port only, clears after load
module vcr_vc0_resource_regs
    import vcr_pkg::*;
#(
    parameter int N_WORDS = TBL_WORDS,
    parameter int IDX_W   = $clog2(N_WORDS)
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // apb slave
    input  wire vcr_apb_req_t     apbReq,
    output vcr_apb_rsp_t          apbRsp,
    // port role strap, high on the upstream port
    input  wire logic             upstreamStrap,
    // table entry logic
    input  wire logic             tableEntryWr,
    // arbiter side
    output logic [7:0]            classMap,
    output logic [2:0]            arbSchemeSel,
    output logic                  tableLoadStrobe,
    output logic [IDX_W-1:0]      tableLoadIdx,
    output logic                  arbTableStatus
);

    // strap synchroniser
    logic strapMeta_q;
    logic strapMeta_d;
    logic isUp_q;
    logic isUp_d;

    always_comb begin
        strapMeta_d = upstreamStrap;
        isUp_d      = strapMeta_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            strapMeta_q <= 1'b0;
            isUp_q      <= 1'b0;
        end else begin
            strapMeta_q <= strapMeta_d;
            isUp_q      <= isUp_d;
        end
    end

    // bus decode
    logic setupPh;
    logic accessPh;
    logic hitCap;
    logic hitCtl;
    logic hitSts;
    logic hitAny;
    logic wrCtl;

    assign setupPh  = apbReq.psel && !apbReq.penable;
    assign accessPh = apbReq.psel && apbReq.penable;

    always_comb begin
        hitCap = 1'b0;
        hitCtl = 1'b0;
        hitSts = 1'b0;
        if (apbReq.paddr == CAP_OFF) begin
            hitCap = 1'b1;
        end else if (apbReq.paddr == CTL_OFF) begin
            hitCtl = 1'b1;
        end else if (apbReq.paddr == STS_OFF) begin
            hitSts = 1'b1;
        end
    end

    assign hitAny = hitCap || hitCtl || hitSts;
    assign wrCtl  = accessPh && apbReq.pwrite && hitCtl;

    // fixed capability and control values
    logic [7:0]  arbCap;
    logic [7:0]  tblOff;
    logic [31:0] capWord;
    logic [31:0] ctlWord;
    logic [31:0] stsWord;

    assign arbCap = isUp_q ? ARB_CAP_UP : ARB_CAP_DN;
    assign tblOff = isUp_q ? TBL_OFF_UP : TBL_OFF_DN;

    always_comb begin
        capWord = 32'h0000_0000;
        capWord[ARB_CAP_LSB +: 8] = arbCap;
        capWord[SLOTS_LSB +: 7]   = SLOTS_VAL;
        capWord[TBL_OFF_LSB +: 8] = tblOff;
    end

    // control register state
    logic [7:1] mapHi_q;
    logic [7:1] mapHi_d;
    logic [2:0] sel_q;
    logic [2:0] sel_d;

    always_comb begin
        mapHi_d = mapHi_q;
        sel_d   = sel_q;
        if (wrCtl) begin
            mapHi_d = apbReq.pwdata[MAP_LSB+1 +: 7];
            sel_d   = apbReq.pwdata[SEL_LSB +: 3];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mapHi_q <= MAP_RST[7:1];
            sel_q   <= SEL_RST;
        end else begin
            mapHi_q <= mapHi_d;
            sel_q   <= sel_d;
        end
    end

    always_comb begin
        ctlWord = 32'h0000_0000;
        ctlWord[MAP_LSB +: 8]     = {mapHi_q, MAP_RST[0]};
        ctlWord[LOAD_BIT]         = 1'b0;
        ctlWord[SEL_LSB +: 3]     = sel_q;
        ctlWord[CHAN_ID_LSB +: 3] = CHAN_ID_VAL;
        ctlWord[CHAN_EN_BIT]      = CHAN_EN_VAL;
    end

    // table load request
    logic tableUsed;
    logic loadStart;
    logic loadBusy;
    logic loadDone;

    // scheme 0 is fixed round robin and needs no table
    assign tableUsed = (sel_q != 3'h0) && arbCap[sel_q];
    assign loadStart = wrCtl && apbReq.pwdata[LOAD_BIT]
                       && isUp_q
                       && tableUsed
                       && !loadBusy;

    vcr_table_loader #(
        .N_WORDS (N_WORDS),
        .IDX_W   (IDX_W)
    ) u_loader (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (loadStart),
        .busy    (loadBusy),
        .done    (loadDone),
        .strobe  (tableLoadStrobe),
        .idx     (tableLoadIdx)
    );

    // table status: an entry write in the finishing cycle keeps it set
    logic sts_q;
    logic sts_d;

    always_comb begin
        sts_d = sts_q;
        if (tableEntryWr) begin
            sts_d = 1'b1;
        end else if (loadDone) begin
            sts_d = 1'b0;
        end
        if (!isUp_q) begin
            sts_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sts_q <= 1'b0;
        end else begin
            sts_q <= sts_d;
        end
    end

    always_comb begin
        stsWord = 32'h0000_0000;
        stsWord[STS_BIT] = sts_q;
    end

    // read data is captured in the setup cycle
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;
    logic        err_d;

    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (setupPh) begin
            err_d   = !hitAny;
            rdata_d = 32'h0000_0000;
            if (!apbReq.pwrite) begin
                if (hitCap) begin
                    rdata_d = capWord;
                end else if (hitCtl) begin
                    rdata_d = ctlWord;
                end else if (hitSts) begin
                    rdata_d = stsWord;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    always_comb begin
        apbRsp.prdata  = rdata_q;
        apbRsp.pready  = 1'b1;
        apbRsp.pslverr = accessPh && err_q;
    end

    assign classMap       = {mapHi_q, MAP_RST[0]};
    assign arbSchemeSel   = sel_q;
    assign arbTableStatus = sts_q;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic rdCap;
    logic rdCtl;
    assign rdCap = setupPh && !apbReq.pwrite && hitCap;
    assign rdCtl = setupPh && !apbReq.pwrite && hitCtl;

    a_slots_zero: assert property (
        rdCap |=> apbRsp.prdata[SLOTS_LSB +: 8] == 8'h00)
        else $error("time slots field or reserved bit not zero");

    a_tbl_offset: assert property (
        rdCap |=> apbRsp.prdata[TBL_OFF_LSB +: 8] == (isUp_q ? 8'h02 : 8'h00))
        else $error("table offset wrong for port role");

    a_arb_capability: assert property (
        rdCap |=> apbRsp.prdata[7:0] == (isUp_q ? 8'h03 : 8'h01))
        else $error("arbitration capability wrong for port role");

    a_map_bit0: assert property (
        rdCtl |=> apbRsp.prdata[0] && classMap[0])
        else $error("class map bit 0 not fixed at one");

    a_map_written: assert property (
        wrCtl |=> classMap[7:1] == $past(apbReq.pwdata[7:1]))
        else $error("class map write not stored");

    a_load_reads_zero: assert property (
        rdCtl |=> !apbRsp.prdata[LOAD_BIT])
        else $error("load trigger read back as one");

    a_load_copies: assert property (
        loadStart |=> tableLoadStrobe && tableLoadIdx == '0 ##1 tableLoadStrobe)
        else $error("table copy not started after load trigger");

    a_load_needs_one: assert property (
        $rose(tableLoadStrobe) |-> $past(wrCtl) && $past(apbReq.pwdata[LOAD_BIT]))
        else $error("load started without a one written");

    a_load_scheme: assert property (
        $rose(tableLoadStrobe) |-> $past(arbSchemeSel) == 3'h1)
        else $error("load started for a scheme without table");

    a_load_upstream: assert property (
        $rose(tableLoadStrobe) |-> $past(isUp_q))
        else $error("load started on downstream port");

    a_sel_reset: assert property (
        $rose(rst_n) |-> arbSchemeSel == 3'h0)
        else $error("scheme select not zero after reset");

    a_chan_fixed: assert property (
        rdCtl |=> apbRsp.prdata[31:24] == 8'h80)
        else $error("channel id or enable not hardwired");

    a_ctl_reserved: assert property (
        rdCtl |=> apbRsp.prdata[15:8] == 8'h00 && apbRsp.prdata[23:20] == 4'h0)
        else $error("reserved control bits not zero");

    a_sts_sets: assert property (
        tableEntryWr && isUp_q && $past(isUp_q) |=> arbTableStatus)
        else $error("status not set after table entry write");

    a_sts_clears: assert property (
        loadDone && !tableEntryWr |=> !arbTableStatus)
        else $error("status not cleared after load finished");

    a_sts_set_wins: assert property (
        tableEntryWr && loadDone && isUp_q |=> arbTableStatus)
        else $error("entry write lost when load finished");

    a_sts_downstream: assert property (
        !isUp_q |=> !arbTableStatus)
        else $error("status set on downstream port");

    a_sel_written: assert property (
        wrCtl |=> arbSchemeSel == $past(apbReq.pwdata[SEL_LSB +: 3]))
        else $error("scheme select write not stored");

    a_map_reads: assert property (
        rdCtl |=> apbRsp.prdata[7:1] == $past(classMap[7:1]))
        else $error("class map read back wrong");

    a_copy_length: assert property (
        loadStart |=> tableLoadStrobe [*4] ##1 !tableLoadStrobe)
        else $error("table copy length wrong");

    c_load_done:   cover property (loadDone);
    c_set_wins:    cover property (tableEntryWr && loadDone);
    c_entry_in_ld: cover property (tableEntryWr && loadBusy);
    c_cap_read_up: cover property (rdCap && isUp_q);
    c_unmapped:    cover property (apbRsp.pslverr);

endmodule
`default_nettype wire

/* logic/vcr_pkg.sv */
// vcr_pkg: offsets, field positions, reset values and carriers for the
// resource 0 register block. Assumes a 32-bit APB master on clk_sys.
package vcr_pkg;

    // register byte addresses
    localparam int          ADDR_W      = 12;
    localparam logic [11:0] CAP_OFF     = 12'h210;
    localparam logic [11:0] CTL_OFF     = 12'h214;
    localparam logic [11:0] STS_OFF     = 12'h218;

    // capability fields
    localparam int          ARB_CAP_LSB = 0;
    localparam int          SLOTS_LSB   = 16;
    localparam int          TBL_OFF_LSB = 24;
    localparam logic [7:0]  ARB_CAP_UP  = 8'h03;
    localparam logic [7:0]  ARB_CAP_DN  = 8'h01;
    localparam logic [6:0]  SLOTS_VAL   = 7'h00;
    localparam logic [7:0]  TBL_OFF_UP  = 8'h02;
    localparam logic [7:0]  TBL_OFF_DN  = 8'h00;

    // control fields
    localparam int          MAP_LSB     = 0;
    localparam int          LOAD_BIT    = 16;
    localparam int          SEL_LSB     = 17;
    localparam int          CHAN_ID_LSB = 24;
    localparam int          CHAN_EN_BIT = 31;
    localparam logic [7:0]  MAP_RST     = 8'hFF;
    localparam logic [2:0]  SEL_RST     = 3'h0;
    localparam logic [2:0]  CHAN_ID_VAL = 3'h0;
    localparam logic        CHAN_EN_VAL = 1'b1;

    // status field
    localparam int          STS_BIT     = 0;

    // arbitration table words copied per load (32 phases, 8 per word)
    localparam int          TBL_WORDS   = 4;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } vcr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } vcr_apb_rsp_t;

endpackage

/* logic/vcr_table_loader.sv */
// vcr_table_loader: walks the arbitration table words once per start,
// one word strobe per cycle. Assumes start is a single-cycle pulse.
`timescale 1ns/1ns
`default_nettype none
module vcr_table_loader
    import vcr_pkg::*;
#(
    parameter int N_WORDS = TBL_WORDS,
    parameter int IDX_W   = $clog2(N_WORDS)
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // control
    input  wire logic             start,
    output logic                  busy,
    output logic                  done,
    // copy strobes
    output logic                  strobe,
    output logic [IDX_W-1:0]      idx
);

    typedef enum logic {LD_IDLE, LD_COPY} vcr_ld_state_t;

    vcr_ld_state_t    state_q;
    vcr_ld_state_t    state_d;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] idx_d;
    logic             lastWord;

    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_WORDS - 1);

    assign lastWord = (idx_q == LAST_IDX);

    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        case (state_q)
            LD_IDLE: begin
                if (start) begin
                    state_d = LD_COPY;
                    idx_d   = '0;
                end
            end
            LD_COPY: begin
                if (lastWord) begin
                    state_d = LD_IDLE;
                end else begin
                    idx_d = idx_q + IDX_W'(1);
                end
            end
            default: state_d = LD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= LD_IDLE;
            idx_q   <= '0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
        end
    end

    assign busy   = (state_q == LD_COPY);
    assign strobe = busy;
    assign idx    = idx_q;
    assign done   = busy && lastWord;

    a_copy_strobe: assert property (@(posedge clk_sys) disable iff (!rst_n)
        start && !busy |=> strobe && idx == '0)
        else $error("copy did not begin at word zero");

endmodule
`default_nettype wire

/* dv/tb.sv */
// tb: self-checking bench for the resource 0 register block.
// assumes the package constants and a zero-wait APB slave on clk_sys.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin nErrors++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb;
    import vcr_pkg::*;

    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] r;
        logic        e;
        logic [7:0]  m;
        logic [2:0]  s;
    } vcr_row_t;

    logic                clk_sys = 1'b0;
    logic                rst_n = 1'b0;
    vcr_apb_req_t        apbReq = '0;
    vcr_apb_rsp_t        apbRsp;
    logic                upstreamStrap = 1'b1;
    logic                tableEntryWr = 1'b0;
    logic [7:0]          classMap;
    logic [2:0]          arbSchemeSel;
    logic                tableLoadStrobe;
    logic [1:0]          tableLoadIdx;
    logic                arbTableStatus;
    logic [31:0]         rdData;
    logic                rdErr;
    int                  nErrors = 0;
    int                  totalChecks = 0;
    int                  nStrobe = 0;
    int                  base;
    vcr_row_t            rows [11];

    always #20 clk_sys = ~clk_sys;

    vcr_vc0_resource_regs #(.N_WORDS(4), .IDX_W(2)) DUT (
        .clk_sys         (clk_sys),
        .rst_n           (rst_n),
        .apbReq          (apbReq),
        .apbRsp          (apbRsp),
        .upstreamStrap   (upstreamStrap),
        .tableEntryWr    (tableEntryWr),
        .classMap        (classMap),
        .arbSchemeSel    (arbSchemeSel),
        .tableLoadStrobe (tableLoadStrobe),
        .tableLoadIdx    (tableLoadIdx),
        .arbTableStatus  (arbTableStatus)
    );

    // copy strobes must walk the words in ascending order
    always @(posedge clk_sys) begin
        if (tableLoadStrobe === 1'b1) begin
            `CHK("tableLoadIdx", nStrobe[1:0], tableLoadIdx)
            nStrobe++;
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        apbReq.psel    <= 1'b1;
        apbReq.penable <= 1'b0;
        apbReq.pwrite  <= w;
        apbReq.paddr   <= a;
        apbReq.pwdata  <= d;
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        @(posedge clk_sys);
        while (apbRsp.pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rdData = apbRsp.prdata;
        rdErr = apbRsp.pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic entryWrite();
        @(posedge clk_sys);
        tableEntryWr <= 1'b1;
        @(posedge clk_sys);
        tableEntryWr <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic doReset(input logic up);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        upstreamStrap <= up;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic conclude();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #(40 * 3000);
        nErrors++;
        conclude();
    end

    initial begin
        rows[0]  = '{1'b0, CAP_OFF, 32'h0000_0000, 32'h0200_0003, 1'b0, 8'hFF, 3'h0};
        rows[1]  = '{1'b0, CTL_OFF, 32'h0000_0000, 32'h8000_00FF, 1'b0, 8'hFF, 3'h0};
        rows[2]  = '{1'b1, CTL_OFF, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0, 8'hFF, 3'h7};
        rows[3]  = '{1'b0, CTL_OFF, 32'h0000_0000, 32'h800E_00FF, 1'b0, 8'hFF, 3'h7};
        rows[4]  = '{1'b1, CAP_OFF, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0, 8'hFF, 3'h7};
        rows[5]  = '{1'b0, CAP_OFF, 32'h0000_0000, 32'h0200_0003, 1'b0, 8'hFF, 3'h7};
        rows[6]  = '{1'b1, CTL_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0, 8'h01, 3'h0};
        rows[7]  = '{1'b0, CTL_OFF, 32'h0000_0000, 32'h8000_0001, 1'b0, 8'h01, 3'h0};
        rows[8]  = '{1'b0, STS_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0, 8'h01, 3'h0};
        rows[9]  = '{1'b0, 12'h21C, 32'h0000_0000, 32'h0000_0000, 1'b1, 8'h01, 3'h0};
        rows[10] = '{1'b1, 12'h21C, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1, 8'h01, 3'h0};
        doReset(1'b1);
        `CHK("classMap", MAP_RST, classMap)
        `CHK("arbTableStatus", 1'b0, arbTableStatus)
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) `CHK("prdata", rows[i].r, rdData)
            `CHK("pslverr", rows[i].e, rdErr)
            @(posedge clk_sys);
            `CHK("classMap", rows[i].m, classMap)
            `CHK("arbSchemeSel", rows[i].s, arbSchemeSel)
        end
        `CHK("strobes", 0, nStrobe)
        // table entry write marks the table stale
        entryWrite();
        `CHK("arbTableStatus", 1'b1, arbTableStatus)
        apb(1'b1, CTL_OFF, 32'h0002_0000);
        // second write: table scheme already stored, trigger written zero
        apb(1'b1, CTL_OFF, 32'h0002_0000);
        repeat (6) @(posedge clk_sys);
        `CHK("strobes", 0, nStrobe)
        apb(1'b1, CTL_OFF, 32'h0003_0000);
        repeat (8) @(posedge clk_sys);
        `CHK("strobes", 4, nStrobe)
        `CHK("arbTableStatus", 1'b0, arbTableStatus)
        apb(1'b0, STS_OFF, 32'h0000_0000);
        `CHK("prdata", 32'h0000_0000, rdData)
        apb(1'b0, CTL_OFF, 32'h0000_0000);
        `CHK("prdata", 32'h8002_0001, rdData)
        // select without a table: load request is dropped
        apb(1'b1, CTL_OFF, 32'h0004_0000);
        apb(1'b1, CTL_OFF, 32'h0005_0000);
        repeat (8) @(posedge clk_sys);
        `CHK("strobes", 4, nStrobe)
        // entry write in the last copy cycle keeps the table stale
        apb(1'b1, CTL_OFF, 32'h0002_0000);
        base = nStrobe;
        apb(1'b1, CTL_OFF, 32'h0003_0000);
        repeat (3) @(posedge clk_sys);
        tableEntryWr <= 1'b1;
        @(posedge clk_sys);
        tableEntryWr <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("strobes", base + 4, nStrobe)
        `CHK("arbTableStatus", 1'b1, arbTableStatus)
        // downstream port after a second reset
        doReset(1'b0);
        `CHK("arbSchemeSel", SEL_RST, arbSchemeSel)
        apb(1'b0, CAP_OFF, 32'h0000_0000);
        `CHK("prdata", 32'h0000_0001, rdData)
        apb(1'b0, CTL_OFF, 32'h0000_0000);
        `CHK("prdata", 32'h8000_00FF, rdData)
        entryWrite();
        `CHK("arbTableStatus", 1'b0, arbTableStatus)
        base = nStrobe;
        apb(1'b1, CTL_OFF, 32'h0002_0000);
        apb(1'b1, CTL_OFF, 32'h0003_0000);
        repeat (8) @(posedge clk_sys);
        `CHK("strobes", base, nStrobe)
        conclude();
    end
endmodule
`undef CHK
`default_nettype wire
